//--- hw/tcp_defines.vh
// Constants for the capture/compare pulse timer
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH
`define TCP_CW          16
`define TCP_CNT_MAX     16'hFFFF
`define TCP_CNT_ZERO    16'h0000
// Prescaler/edge register field positions
`define TCP_PRM_CLK_LO  0
`define TCP_PRM_CLK_HI  1
`define TCP_PRM_ES0_LO  4
`define TCP_PRM_ES0_HI  5
`define TCP_PRM_ES1_LO  6
`define TCP_PRM_ES1_HI  7
// Count clock selection codes
`define TCP_CLK_DIV1    2'h0
`define TCP_CLK_DIV4    2'h1
`define TCP_CLK_DIV64   2'h2
`define TCP_CLK_EXT     2'h3
`define TCP_DIV4_LAST   6'h03
`define TCP_DIV64_LAST  6'h3F
// Edge selection codes
`define TCP_ES_FALL     2'h0
`define TCP_ES_RISE     2'h1
`define TCP_ES_BOTH     2'h3
// Operating modes
`define TCP_MODE_STOP   3'h0
`define TCP_MODE_FREE1  3'h1
`define TCP_MODE_FREE2  3'h2
`define TCP_MODE_FREECR 3'h3
`define TCP_MODE_RESTRT 3'h4
`define TCP_MODE_SQW    3'h5
`define TCP_MODE_PPG    3'h6
// Output control field positions
`define TCP_OC_OE       0
`define TCP_OC_TGA      1
`define TCP_OC_LVR      2
`define TCP_OC_LVS      3
`define TCP_OC_TGB      4
`endif

//--- hw/tcp_edge_filter.v
// Two-sample noise filter and edge detector for one capture input
`timescale 1ns/100ps
`default_nettype none
`include "tcp_defines.vh"
module tcp_edge_filter (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_pin,
    input  wire       i_sample,
    input  wire [1:0] i_edge_sel,
    output wire       o_edge,
    output wire       o_rise,
    output wire       o_fall
);
    reg sync1_r;
    reg sync2_r;
    reg samp_a_r;
    reg samp_b_r;
    reg level_r;
    wire level_nxt;

    // Two-flop synchroniser; the first stage feeds only the second
    always @(posedge i_clk) begin
        if (i_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
        end
    end

    // Level only accepted after two equal samples, rejecting short glitches
    always @(posedge i_clk) begin
        if (i_rst) begin
            samp_a_r <= 1'b0;
            samp_b_r <= 1'b0;
            level_r  <= 1'b0;
        end else if (i_sample) begin
            samp_a_r <= sync2_r;
            samp_b_r <= samp_a_r;
            level_r  <= level_nxt;
        end
    end
    assign level_nxt = (samp_a_r == samp_b_r) ? samp_b_r : level_r; // [RULE4]

    // Edges are one-cycle pulses in the cycle the filtered level changes
    assign o_rise = i_sample & level_nxt & ~level_r;
    assign o_fall = i_sample & ~level_nxt & level_r;
    assign o_edge = (i_edge_sel == `TCP_ES_RISE) ? o_rise :
                    (i_edge_sel == `TCP_ES_FALL) ? o_fall :
                    (i_edge_sel == `TCP_ES_BOTH) ? (o_rise | o_fall) : 1'b0; // [RULE3]
endmodule // tcp_edge_filter
`default_nettype wire

//--- hw/tcp_timer.v
// Capture/compare timer: pulse width measurement, square wave and PPG output
// Notes on behaviour
// RULE1: Two-pulse mode: primary edge captures into B, irq B
// RULE2: Two-pulse mode: secondary edge captures into A, irq A
// RULE3: Each input selects rise, fall or both
// RULE4: Capture only after two equal input samples
// RULE5: Software clears overflow flag; hardware never does
// RULE6: Two-register mode: opposite primary edge captures into A
// RULE7: Software picks rise or fall in two-register mode
// RULE8: Both-edge primary selection blocks captures into A
// RULE9: Restart mode: capture into B, then clear counter
// RULE10: Software picks rise or fall in restart mode
// RULE11: Output enable plus toggle-A inverts pin on match
// RULE12: Square wave clears counter on A match
// RULE13: Level set/reset bits preload output flip-flop
// RULE14: Toggle-B cleared leaves pin unchanged on B match
// RULE15: PPG: period from A, width from B
// RULE16: Software keeps 0 < B < A <= FFFF
// RULE17: PPG period A+1, high time B+1 counts
// RULE18: Prescaler low bits select count clock source
// RULE19: Software stops timer before prescaler writes
// RULE20: Free-run counter wraps and sets overflow flag
// RULE21: Interrupt requests are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "tcp_defines.vh"
module tcp_timer (
    input  wire                 i_clk,
    input  wire                 i_rst,
    input  wire                 i_primary_capture_input,
    input  wire                 i_secondary_capture_input,
    input  wire [7:0]           i_prescaler_edge_register,
    input  wire [2:0]           i_timer_mode_control,
    input  wire [4:0]           i_output_control_register,
    input  wire                 i_output_level_wr,
    input  wire                 i_overflow_clear,
    input  wire                 i_cca_wr,
    input  wire                 i_ccb_wr,
    input  wire [`TCP_CW-1:0]   i_wr_data,
    output reg  [`TCP_CW-1:0]   o_timer_counter,
    output reg  [`TCP_CW-1:0]   o_capture_compare_a,
    output reg  [`TCP_CW-1:0]   o_capture_compare_b,
    output reg                  o_counter_overflow_flag,
    output wire                 o_irq_match_a,
    output wire                 o_irq_match_b,
    output reg                  o_timer_output_pin,
    output wire                 o_timer_output_oe
);
    reg  [5:0] presc_r;
    reg        tick_int;
    wire       tick;
    wire [1:0] clk_sel  = i_prescaler_edge_register[`TCP_PRM_CLK_HI:`TCP_PRM_CLK_LO];
    wire [1:0] es_prim  = i_prescaler_edge_register[`TCP_PRM_ES0_HI:`TCP_PRM_ES0_LO];
    wire [1:0] es_sec   = i_prescaler_edge_register[`TCP_PRM_ES1_HI:`TCP_PRM_ES1_LO];
    wire [2:0] mode     = i_timer_mode_control;
    wire       running  = (mode != `TCP_MODE_STOP);
    wire       prim_edge;
    wire       prim_rise;
    wire       prim_fall;
    wire       sec_edge;
    wire       oc_oe    = i_output_control_register[`TCP_OC_OE];
    wire       oc_tga   = i_output_control_register[`TCP_OC_TGA];
    wire       oc_lvr   = i_output_control_register[`TCP_OC_LVR];
    wire       oc_lvs   = i_output_control_register[`TCP_OC_LVS];
    wire       oc_tgb   = i_output_control_register[`TCP_OC_TGB];
    wire       filt_samp;

    // Free prescaler; the divider runs always so the filter has a sample rate
    always @(posedge i_clk) begin
        if (i_rst) begin
            presc_r <= 6'h00;
        end else begin
            presc_r <= presc_r + 6'h01;
        end
    end

    // Count clock source selection
    always @* begin
        case (clk_sel)
            `TCP_CLK_DIV1:  tick_int = 1'b1;
            `TCP_CLK_DIV4:  tick_int = (presc_r[1:0] == `TCP_DIV4_LAST);
            `TCP_CLK_DIV64: tick_int = (presc_r == `TCP_DIV64_LAST);
            default:        tick_int = 1'b1;
        endcase
    end
    // External source samples on the main clock, counts on primary edges
    assign filt_samp = (clk_sel == `TCP_CLK_EXT) ? 1'b1 : tick_int;  // [RULE18]
    assign tick      = (clk_sel == `TCP_CLK_EXT) ? prim_edge : tick_int; // [RULE18]

    tcp_edge_filter u_prim (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_primary_capture_input),
        .i_sample   (filt_samp),
        .i_edge_sel (es_prim),
        .o_edge     (prim_edge),
        .o_rise     (prim_rise),
        .o_fall     (prim_fall)
    );

    tcp_edge_filter u_sec (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_secondary_capture_input),
        .i_sample   (filt_samp),
        .i_edge_sel (es_sec),
        .o_edge     (sec_edge),
        .o_rise     (),
        .o_fall     ()
    );

    // Capture and compare events
    wire cap_mode  = (mode == `TCP_MODE_FREE1) | (mode == `TCP_MODE_FREE2) |
                     (mode == `TCP_MODE_FREECR) | (mode == `TCP_MODE_RESTRT);
    wire ext_clk   = (clk_sel == `TCP_CLK_EXT);
    wire cap_b     = cap_mode & ~ext_clk & prim_edge;           // [RULE1] [RULE9]
    wire opp_edge  = (es_prim == `TCP_ES_RISE) ? prim_fall :
                     (es_prim == `TCP_ES_FALL) ? prim_rise : 1'b0; // [RULE8]
    wire cap_a_sec = (mode == `TCP_MODE_FREE2) & sec_edge;      // [RULE2]
    wire cap_a_opp = (mode == `TCP_MODE_FREECR) & ~ext_clk & opp_edge; // [RULE6] [RULE8]
    wire cmp_mode  = (mode == `TCP_MODE_SQW) | (mode == `TCP_MODE_PPG);
    wire match_a   = cmp_mode & tick & (o_timer_counter == o_capture_compare_a);
    wire match_b   = cmp_mode & tick & (o_timer_counter == o_capture_compare_b);
    wire restart   = (mode == `TCP_MODE_RESTRT) & cap_b;        // [RULE9]
    wire wrap      = running & ~cmp_mode & ~restart & tick &
                     (o_timer_counter == `TCP_CNT_MAX);

    // Interrupt requests pulse for exactly the event cycle
    assign o_irq_match_b = running & (cap_b | match_b);          // [RULE21] [RULE1]
    assign o_irq_match_a = running & (cap_a_sec | match_a);      // [RULE21] [RULE2]

    // Counter: stop, restart and compare A match clear it, otherwise free-runs
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_timer_counter <= `TCP_CNT_ZERO;
        end else if (!running) begin
            o_timer_counter <= `TCP_CNT_ZERO;
        end else if (restart) begin
            o_timer_counter <= `TCP_CNT_ZERO;                    // [RULE9]
        end else if (match_a) begin
            o_timer_counter <= `TCP_CNT_ZERO;                    // [RULE12] [RULE17]
        end else if (tick) begin
            o_timer_counter <= o_timer_counter + 16'h0001;       // [RULE20]
        end
    end

    // Overflow flag: hardware set wins over a same-cycle software clear
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_counter_overflow_flag <= 1'b0;
        end else if (wrap) begin
            o_counter_overflow_flag <= 1'b1;                     // [RULE20]
        end else if (i_overflow_clear) begin
            o_counter_overflow_flag <= 1'b0;                     // [RULE5]
        end
    end

    // Capture/compare A: capture wins over a software write in the same cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_capture_compare_a <= `TCP_CNT_ZERO;
        end else if (running & (cap_a_sec | cap_a_opp)) begin
            o_capture_compare_a <= o_timer_counter;              // [RULE2] [RULE6]
        end else if (i_cca_wr) begin
            o_capture_compare_a <= i_wr_data;
        end
    end

    // Capture/compare B; the captured value is the count before any restart
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_capture_compare_b <= `TCP_CNT_ZERO;
        end else if (running & cap_b) begin
            o_capture_compare_b <= o_timer_counter;              // [RULE1] [RULE9]
        end else if (i_ccb_wr) begin
            o_capture_compare_b <= i_wr_data;
        end
    end

    // Output flip-flop. In PPG mode the pin goes low on B match and high on
    // A match, so the high time is B+1 counts out of A+1.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_timer_output_pin <= 1'b0;
        end else if (i_output_level_wr & oc_lvs & ~oc_lvr) begin
            o_timer_output_pin <= 1'b1;                          // [RULE13]
        end else if (i_output_level_wr & oc_lvr & ~oc_lvs) begin
            o_timer_output_pin <= 1'b0;                          // [RULE13]
        end else if (oc_oe & (mode == `TCP_MODE_PPG)) begin
            if (match_a) begin
                o_timer_output_pin <= 1'b1;                      // [RULE15] [RULE17]
            end else if (match_b) begin
                o_timer_output_pin <= 1'b0;                      // [RULE15] [RULE17]
            end
        end else if (oc_oe & ((match_a & oc_tga) ^ (match_b & oc_tgb))) begin
            o_timer_output_pin <= ~o_timer_output_pin;           // [RULE11] [RULE14]
        end
    end

    assign o_timer_output_oe = oc_oe;                            // [RULE11]
endmodule // tcp_timer
`default_nettype wire

//--- sim/tcp_properties.sv
// Port-level assertion checker for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tcp_properties (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_prescaler_edge_register,
    input wire logic [2:0]  i_timer_mode_control,
    input wire logic [4:0]  i_output_control_register,
    input wire logic        i_output_level_wr,
    input wire logic        i_overflow_clear,
    input wire logic        i_cca_wr,
    input wire logic [15:0] o_timer_counter,
    input wire logic [15:0] o_capture_compare_a,
    input wire logic [15:0] o_capture_compare_b,
    input wire logic        o_counter_overflow_flag,
    input wire logic        o_irq_match_a,
    input wire logic        o_irq_match_b,
    input wire logic        o_timer_output_pin
);
    // Short aliases keep all properties but p_wrap, p_tog_a and p_no_a on one line
    wire [2:0]  md  = i_timer_mode_control;
    wire [15:0] cnt = o_timer_counter;
    wire        ia  = o_irq_match_a;
    wire        ib  = o_irq_match_b;
    wire        pin = o_timer_output_pin;
    wire        lw  = i_output_level_wr;
    wire        cap = md inside {3'h1, 3'h2, 3'h3, 3'h4};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_irq_one; cap && ib |=> !ib; endproperty
    a_irq_one: assert property (p_irq_one) else $error("irq b longer than one cycle");
    property p_cap_b; cap && ib |=> o_capture_compare_b == $past(cnt); endproperty
    a_cap_b: assert property (p_cap_b) else $error("capture b value wrong");
    property p_cap_a; md == 3'h2 && ia |=> o_capture_compare_a == $past(cnt); endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture a value wrong");
    property p_restart; md == 3'h4 && ib |=> cnt == 16'h0000; endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");
    property p_wrap;
        md inside {3'h1, 3'h2, 3'h3} && i_prescaler_edge_register[1:0] == 2'h0
            && cnt == 16'hFFFF ##1 md inside {3'h1, 3'h2, 3'h3}
            |-> cnt == 16'h0000 && o_counter_overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong");
    property p_sticky; o_counter_overflow_flag && !i_overflow_clear |=> o_counter_overflow_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("overflow lost");
    property p_tog_a; md == 3'h5 && i_output_control_register[1:0] == 2'h3 && ia && !lw
        |=> pin != $past(pin); endproperty
    a_tog_a: assert property (p_tog_a) else $error("no toggle on match");
    property p_sqw_clr; md == 3'h5 && ia |=> cnt == 16'h0000; endproperty
    a_sqw_clr: assert property (p_sqw_clr) else $error("square wave no clear");
    property p_no_a; md == 3'h3 && i_prescaler_edge_register[5:4] == 2'h3 && !i_cca_wr
        |=> $stable(o_capture_compare_a); endproperty
    a_no_a: assert property (p_no_a) else $error("capture a with both edges");
    property p_ppg_hi; md == 3'h6 && i_output_control_register[0] && ia && !lw |=> pin; endproperty
    a_ppg_hi: assert property (p_ppg_hi) else $error("pulse not started");
endmodule // tcp_properties
bind tcp_timer tcp_properties u_props (.i_clk, .i_rst, .i_prescaler_edge_register,
    .i_timer_mode_control, .i_output_control_register, .i_output_level_wr, .i_overflow_clear,
    .i_cca_wr, .o_timer_counter, .o_capture_compare_a, .o_capture_compare_b,
    .o_counter_overflow_flag, .o_irq_match_a, .o_irq_match_b, .o_timer_output_pin);
`default_nettype wire

//--- sim/tcp_pin_src.sv
// Behavioural external pulse source for one capture input pin
`timescale 1ns/100ps
`default_nettype none
module tcp_pin_src (
    input  wire logic i_clk,
    input  wire logic i_lvl,
    input  wire logic i_spike,
    output var  logic o_pin
);
    // A spike flips the pin for one clock, too short to pass the filter
    initial o_pin = 1'b0;
    always @(posedge i_clk) o_pin <= i_lvl ^ i_spike;
endmodule // tcp_pin_src
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk = 0, rst = 1, lw = 0, oclr = 0, wa = 0, wb = 0;
    logic        pl = 0, pk = 0, sl = 0;
    logic [7:0]  pre = 8'h00;
    logic [2:0]  md = 3'h0;
    logic [4:0]  oc = 5'h00;
    logic [15:0] wd = 16'h0000, t0;
    logic [15:0] per [3] = '{16'h0005, 16'h0014, 16'h0140};
    wire  [15:0] cnt, ca, cb;
    wire         ovf, ia, ib, pin, oe, pp, ps;
    wire  [3:0]  ev = {ovf, pin, ia, ib};
    int          fails = 0, comparisons = 0, n, hi;
    tcp_timer dut (.i_clk(clk), .i_rst(rst), .i_primary_capture_input(pp),
        .i_secondary_capture_input(ps), .i_prescaler_edge_register(pre),
        .i_timer_mode_control(md), .i_output_control_register(oc), .i_output_level_wr(lw),
        .i_overflow_clear(oclr), .i_cca_wr(wa), .i_ccb_wr(wb), .i_wr_data(wd),
        .o_timer_counter(cnt), .o_capture_compare_a(ca), .o_capture_compare_b(cb),
        .o_counter_overflow_flag(ovf), .o_irq_match_a(ia), .o_irq_match_b(ib),
        .o_timer_output_pin(pin), .o_timer_output_oe(oe));
    tcp_pin_src u_pri (.i_clk(clk), .i_lvl(pl), .i_spike(pk), .o_pin(pp));
    tcp_pin_src u_sec (.i_clk(clk), .i_lvl(sl), .i_spike(1'b0), .o_pin(ps));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k); repeat (k) @(negedge clk); endtask
    // Bounded wait; the count doubles as a level duration
    task automatic wait_ev(input int i, input logic v, output int k);
        k = 0;
        while (ev[i] !== v && k < 70000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 70000) chk(16'h0000, 16'h0001);
    endtask
    // Prescaler only changes while stopped, to avoid a half-applied setting
    task automatic mode(input logic [2:0] m, input logic [7:0] p);
        md = 3'h0;
        cyc(1);
        pre = p;
        md = m;
    endtask
    task automatic wr(input logic a, input logic [15:0] v);
        wd = v;
        if (a) wa = 1;
        else wb = 1;
        cyc(1);
        wa = 0;
        wb = 0;
    endtask
    task automatic conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        conclude;
    end
    initial begin
        cyc(12);
        rst = 0;
        chk(cnt, 16'h0000);
        chk(cb, 16'h0000);
        // Two pulses: primary rise only, secondary both edges
        mode(3'h2, 8'hD0);
        cyc(5);
        pl = 1;
        cyc(7);
        sl = 1;
        cyc(9);
        chk(ca - cb, 16'h0007);
        pl = 0;
        sl = 0;
        wait_ev(1, 1'b1, n);
        cyc(1);
        chk(ca - cb, 16'h0010);
        t0 = cb;
        pk = 1;
        cyc(1);
        pk = 0;
        cyc(10);
        chk(cb, t0);
        $display("two-pulse test done");
        wait_ev(3, 1'b1, n);
        cyc(3);
        chk({15'h0000, ovf}, 16'h0001);
        oclr = 1;
        cyc(1);
        oclr = 0;
        cyc(1);
        chk({15'h0000, ovf}, 16'h0000);
        $display("overflow test done");
        mode(3'h3, 8'h10);
        pl = 1;
        cyc(11);
        pl = 0;
        cyc(10);
        chk(ca - cb, 16'h000B);
        mode(3'h3, 8'h30);
        t0 = ca;
        pl = 1;
        cyc(10);
        pl = 0;
        cyc(10);
        chk(ca, t0);
        $display("two-register test done");
        mode(3'h4, 8'h10);
        repeat (2) begin
            pl = 1;
            cyc(5);
            pl = 0;
            cyc(20);
        end
        chk(cb, 16'h0018);
        $display("restart test done");
        mode(3'h1, 8'h10);
        pl = 1;
        cyc(8);
        pl = 0;
        chk(cb, 16'h0005);
        $display("one-capture test done");
        mode(3'h0, 8'h00);
        oc = 5'h08;
        lw = 1;
        cyc(1);
        lw = 0;
        chk({15'h0000, pin}, 16'h0001);
        oc = 5'h04;
        lw = 1;
        cyc(1);
        lw = 0;
        chk({15'h0000, pin}, 16'h0000);
        wr(1'b1, 16'h0004);
        wr(1'b0, 16'h0002);
        oc = 5'h03;
        chk({15'h0000, oe}, 16'h0001);
        // Half period is (A+1) count clocks at each internal prescaler setting (div 1, 4, 64)
        for (int s = 0; s < 3; s++) begin
            mode(3'h5, 8'(s));
            wait_ev(2, 1'b0, n);
            wait_ev(2, 1'b1, n);
            wait_ev(2, 1'b0, n);
            chk(n[15:0], per[s]);
        end
        $display("square-wave test done");
        mode(3'h0, 8'h00);
        wr(1'b1, 16'h0009);
        wr(1'b0, 16'h0003);
        mode(3'h6, 8'h00);
        wait_ev(2, 1'b0, n);
        wait_ev(2, 1'b1, n);
        wait_ev(2, 1'b0, hi);
        wait_ev(2, 1'b1, n);
        chk(hi[15:0], 16'h0004);
        chk(16'(hi + n), 16'h000A);
        $display("pulse generator test done");
        conclude;
    end
endmodule // tb
`default_nettype wire
